//--- bench/fws_flash_model.sv
// Behavioural flash status source for the poller bench.
// Assumes the bench arms one operation at a time.
`timescale 1ns/1ps
module fws_flash_model
   import fws_pkg::*;
(
   input  wire logic       chip_enable_n,
   input  wire logic       output_enable_n,
   input  wire logic       write_enable_n,
   input  wire logic       flash_dq_oe,
   input  wire logic [7:0] flash_dq_out,
   output logic      [7:0] flash_dq_in,
   input  wire logic       arm,
   input  wire logic [3:0] busy_reads,
   input  wire logic       fail_mode,
   input  wire logic       susp_mode,
   input  wire logic [7:0] array_byte
);
   logic       t1     = 1'h0;
   logic       t2     = 1'h0;
   logic       failed = 1'h0;
   logic [7:0] last   = 8'h00;
   logic [7:0] stat;
   int         n      = 0;
   // Status byte offered on a read
   always_comb begin
      if (susp_mode)
         stat = {1'h1, t1, 1'h0, 2'h0, t2, 2'h0};
      else if (n != 0 || failed)
         stat = {~array_byte[7], t1, failed, 1'h0, 1'h1, 3'h0};
      else
         stat = array_byte;
   end
   // Released lines show a changed pattern, never a held value
   assign flash_dq_in = (!chip_enable_n && !output_enable_n) ? stat : ~last;
   // A finished read moves the toggle bits
   always @(posedge (chip_enable_n | output_enable_n)) begin
      last = stat;
      if (susp_mode)
         t2 = ~t2;
      if (n != 0 || failed)
         t1 = ~t1;
      if (n != 0)
         n = n - 1;
   end
   // Start an operation
   always @(posedge arm) begin
      n = int'(busy_reads);
      failed = fail_mode;
   end
   // Reset command leaves the failure state
   always @(negedge write_enable_n) begin
      #1;
      if (!chip_enable_n && flash_dq_oe && flash_dq_out == CMD_RESET)
         failed = 1'h0;
   end
endmodule

//--- bench/fws_poller_bench.sv
// Self-checking bench for the flash write status poller.
// Assumes the flash model stands on the poller's pins.
`timescale 1ns/1ps
module fws_poller_bench
   import fws_pkg::*;
;
   logic        aclk = 1'h0, aresetn = 1'h0, arm = 1'h0, fail_mode = 1'h0, susp_mode = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        chip_enable_n, output_enable_n, write_enable_n, flash_dq_oe;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, busy_reads = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [18:0] flash_addr;
   logic [7:0]  flash_dq_in, flash_dq_out, array_byte = 8'h5A;
   int          n_fail = 0, compares = 0;
   always #10 aclk = ~aclk;
   fws_poller fws_poller_inst (.*);
   fws_flash_model fws_flash_model_inst (.*);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wrap_up;
      $display("Compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Bus write; each handshake and the response are taken at the rising edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic b;
      int   i;
      b = 1'h0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      for (i = 0; i < 100 && !b; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         {b, r} = {s_axi_bvalid, s_axi_bresp};
      end
      s_axi_bready <= 1'h0;
      @(posedge aclk);
      if (!b) begin n_fail++; wrap_up(); end
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic v;
      int   i;
      v = 1'h0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      for (i = 0; i < 100 && !v; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         {v, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      end
      s_axi_rready <= 1'h0;
      @(posedge aclk);
      if (!v) begin n_fail++; wrap_up(); end
   endtask
   // Arm the flash, start a poll and wait for it to leave busy
   task automatic run(input logic [3:0] nb, input logic f, input logic [31:0] ctrl, output logic [31:0] st);
      logic [1:0] r;
      int         i;
      busy_reads <= nb;
      fail_mode <= f;
      arm <= 1'h1;
      @(posedge aclk);
      arm <= 1'h0;
      wr(REG_CTRL, ctrl, r);
      for (i = 0; i < 400; i++) begin
         rd(REG_STATUS, st, r);
         if (st[ST_BUSY] === 1'h0) break;
      end
      if (i == 400) begin n_fail++; wrap_up(); end
   endtask
   task automatic s_regs;
      logic [31:0] d;
      logic [1:0]  r;
      wr(REG_STATUS, 32'h0000_00FF, r);
      check("status write resp", r, RESP_SLVERR);
      wr(REG_ADDR, 32'h0007_1234, r);
      rd(REG_ADDR, d, r);
      check("status address", d[18:0], 19'h7_1234);
   endtask
   task automatic s_done;
      logic [31:0] st;
      run(4'h3, 1'h0, 32'h0000_0001, st);
      check("done", st[ST_DONE], 1'h1);
      check("fail", st[ST_FAIL], 1'h0);
      check("data", st[15:8], array_byte);
   endtask
   task automatic s_fail;
      logic [31:0] st;
      run(4'h0, 1'h1, 32'h0000_0009, st);
      check("fail", st[ST_FAIL], 1'h1);
      check("window", st[ST_WINDOW], 1'h1);
      check("flash left failure", fws_flash_model_inst.failed, 1'h0);
   endtask
   task automatic s_susp;
      logic [31:0] st;
      susp_mode <= 1'h1;
      run(4'h0, 1'h0, 32'h0000_0001, st);
      check("suspended", st[ST_SUSPENDED], 1'h1);
      check("in sector", st[ST_IN_SECTOR], 1'h1);
      susp_mode <= 1'h0;
   endtask
   task automatic s_data;
      logic [31:0] st;
      run(4'h4, 1'h0, 32'h0000_5A03, st);
      check("data poll done", st[ST_DONE], 1'h1);
      check("data poll byte", st[15:8], array_byte);
   endtask
   task automatic s_quit;
      logic [31:0] st;
      logic [1:0]  r;
      wr(REG_CTRL, 32'h0000_0001, r);
      run(4'hF, 1'h0, 32'h0000_0004, st);
      check("abandon done", st[ST_DONE], 1'h0);
      run(4'h2, 1'h0, 32'h0000_0001, st);
      check("restart done", st[ST_DONE], 1'h1);
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      s_regs();
      s_done();
      s_fail();
      s_susp();
      s_data();
      s_quit();
      wrap_up();
   end
endmodule

//--- bench/fws_poller_properties.sv
// Checker for the poller's flash pins.
// Assumes it is bound into fws_poller.
`timescale 1ns/1ps
module fws_poller_properties
   import fws_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        chip_enable_n,
   input wire logic        output_enable_n,
   input wire logic        write_enable_n,
   input wire logic        flash_dq_oe,
   input wire logic [7:0]  flash_dq_out,
   input wire logic [18:0] flash_addr
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Bus cycle shape and ownership of the data lines
   oe_in_write_a: assert property (flash_dq_oe |-> !write_enable_n && !chip_enable_n)
      else $error("data lines driven outside a write");
   reset_byte_a: assert property (flash_dq_oe |-> flash_dq_out == CMD_RESET)
      else $error("written byte is not the reset command");
   no_clash_a: assert property (!output_enable_n |-> write_enable_n && !flash_dq_oe && !chip_enable_n)
      else $error("read overlaps a write");
   read_len_a: assert property ($fell(output_enable_n) |-> !output_enable_n[*6] ##1 output_enable_n)
      else $error("read strobe length wrong");
   write_len_a: assert property ($fell(write_enable_n) |-> !write_enable_n[*3] ##1 write_enable_n)
      else $error("write strobe length wrong");
   idle_gap_a: assert property ($rose(chip_enable_n) |-> chip_enable_n[*2])
      else $error("idle gap too short");
   addr_hold_a: assert property (!chip_enable_n && !$fell(chip_enable_n) |-> $stable(flash_addr))
      else $error("address moved in a cycle");
   read_pair_a: assert property ($rose(output_enable_n) |-> (write_enable_n && chip_enable_n)[*2])
      else $error("write follows read without gap");
   // Main scenarios
   cover property ($fell(output_enable_n));
   cover property ($fell(write_enable_n));
   cover property ($rose(output_enable_n) ##[2:4] $fell(output_enable_n));
endmodule

bind fws_poller fws_poller_properties fws_poller_properties_inst (.*);

//--- design/fws_axil.sv
// AXI4-Lite slave passing control and address writes to the poller and returning its control, address, status and data words.
// Assumes one outstanding write and one outstanding read from the master.
`timescale 1ns/1ps
module fws_axil
   import fws_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             wr_pulse,
   output logic [3:0]       wr_addr,
   output logic [31:0]      wr_data,
   input  wire logic [31:0] rd_ctrl,
   input  wire logic [31:0] rd_addr,
   input  wire logic [31:0] rd_status,
   input  wire logic [31:0] rd_dataw
);
   logic        aw_reg, aw_next;
   logic        w_reg, w_next;
   logic [3:0]  awa_reg, awa_next;
   logic [31:0] wd_reg, wd_next;
   logic        bv_reg, bv_next;
   logic [1:0]  br_reg, br_next;
   logic        rv_reg, rv_next;
   logic [31:0] rdat_reg, rdat_next;
   logic [1:0]  rr_reg, rr_next;
   logic        wp_reg, wp_next;

   assign s_axi_awready = !aw_reg && !bv_reg;
   assign s_axi_wready  = !w_reg && !bv_reg;
   assign s_axi_bvalid  = bv_reg;
   assign s_axi_bresp   = br_reg;
   assign s_axi_arready = !rv_reg;
   assign s_axi_rvalid  = rv_reg;
   assign s_axi_rdata   = rdat_reg;
   assign s_axi_rresp   = rr_reg;
   assign wr_pulse      = wp_reg;
   assign wr_addr       = awa_reg;
   assign wr_data       = wd_reg;

   // Write and read channel bookkeeping
   always_comb begin
      aw_next   = aw_reg;
      w_next    = w_reg;
      awa_next  = awa_reg;
      wd_next   = wd_reg;
      bv_next   = bv_reg;
      br_next   = br_reg;
      rv_next   = rv_reg;
      rdat_next = rdat_reg;
      rr_next   = rr_reg;
      wp_next   = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_next  = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_next  = 1'b1;
         wd_next = s_axi_wstrb[0] ? s_axi_wdata : RESP_ZERO;
      end
      if (aw_reg && w_reg) begin
         aw_next = 1'b0;
         w_next  = 1'b0;
         bv_next = 1'b1;
         wp_next = (awa_reg == REG_CTRL) || (awa_reg == REG_ADDR);
         br_next = wp_next ? RESP_OKAY : RESP_SLVERR;
      end
      if (bv_reg && s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_next = 1'b1;
         rr_next = RESP_OKAY;
         case (s_axi_araddr)
            REG_CTRL:   rdat_next = rd_ctrl;
            REG_ADDR:   rdat_next = rd_addr;
            REG_STATUS: rdat_next = rd_status;
            REG_DATA:   rdat_next = rd_dataw;
            default: begin
               rdat_next = RESP_ZERO;
               rr_next   = RESP_SLVERR;
            end
         endcase
      end else if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
   end

   // Channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg   <= 1'b0;
         w_reg    <= 1'b0;
         awa_reg  <= 4'h0;
         wd_reg   <= 32'h0000_0000;
         bv_reg   <= 1'b0;
         br_reg   <= 2'h0;
         rv_reg   <= 1'b0;
         rdat_reg <= 32'h0000_0000;
         rr_reg   <= 2'h0;
         wp_reg   <= 1'b0;
      end else begin
         aw_reg   <= aw_next;
         w_reg    <= w_next;
         awa_reg  <= awa_next;
         wd_reg   <= wd_next;
         bv_reg   <= bv_next;
         br_reg   <= br_next;
         rv_reg   <= rv_next;
         rdat_reg <= rdat_next;
         rr_reg   <= rr_next;
         wp_reg   <= wp_next;
      end
   end
endmodule

//--- design/fws_pins.sv
// Pin driver: runs one read or write cycle on the flash byte bus.
// Assumes the flash meets its access time within the strobe counts of the package.
`timescale 1ns/1ps
module fws_pins
   import fws_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire fws_req_s    req,
   output logic             done_pulse,
   output logic [7:0]       rdata,
   output logic [18:0]      flash_addr,
   output logic             chip_enable_n,
   output logic             output_enable_n,
   output logic             write_enable_n,
   input  wire logic [7:0]  flash_dq_in,
   output logic [7:0]       flash_dq_out,
   output logic             flash_dq_oe
);
   typedef enum logic [1:0] {PIN_IDLE, PIN_STROBE, PIN_GAP} fws_pin_e;
   fws_pin_e    st_reg, st_next;
   logic [7:0]  cnt_reg, cnt_next;
   logic [7:0]  rd_reg, rd_next;
   logic        wr_reg, wr_next;
   logic [18:0] a_reg, a_next;
   logic [7:0]  wd_reg, wd_next;
   logic        dn_reg, dn_next;

   assign req_ready       = (st_reg == PIN_IDLE);
   assign done_pulse      = dn_reg;
   assign rdata           = rd_reg;
   assign flash_addr      = a_reg;
   assign flash_dq_out    = wd_reg;
   assign flash_dq_oe     = (st_reg == PIN_STROBE) && wr_reg;
   assign chip_enable_n   = !(st_reg == PIN_STROBE);
   assign output_enable_n = !((st_reg == PIN_STROBE) && !wr_reg);
   assign write_enable_n  = !((st_reg == PIN_STROBE) && wr_reg);

   // Strobe sequencing; each completed read ends on the enable rising edge
   always_comb begin
      st_next  = st_reg;
      cnt_next = cnt_reg;
      rd_next  = rd_reg;
      wr_next  = wr_reg;
      a_next   = a_reg;
      wd_next  = wd_reg;
      dn_next  = 1'b0;
      case (st_reg)
         PIN_IDLE: begin
            if (req_valid) begin
               st_next  = PIN_STROBE;
               wr_next  = req.write;
               a_next   = req.addr;
               wd_next  = req.wdata;
               cnt_next = req.write ? 8'(WR_STROBE_CYC) : 8'(RD_STROBE_CYC);
            end
         end
         PIN_STROBE: begin
            if (cnt_reg == 8'h01) begin
               st_next  = PIN_GAP;
               cnt_next = 8'(GAP_CYC);
               if (!wr_reg) begin
                  rd_next = flash_dq_in;
               end
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         PIN_GAP: begin
            if (cnt_reg == 8'h01) begin
               st_next = PIN_IDLE;
               dn_next = 1'b1;
            end else begin
               cnt_next = cnt_reg - 8'h01;
            end
         end
         default: st_next = PIN_IDLE;
      endcase
   end

   // State registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg  <= PIN_IDLE;
         cnt_reg <= 8'h00;
         rd_reg  <= 8'h00;
         wr_reg  <= 1'b0;
         a_reg   <= 19'h00000;
         wd_reg  <= 8'h00;
         dn_reg  <= 1'b0;
      end else begin
         st_reg  <= st_next;
         cnt_reg <= cnt_next;
         rd_reg  <= rd_next;
         wr_reg  <= wr_next;
         a_reg   <= a_next;
         wd_reg  <= wd_next;
         dn_reg  <= dn_next;
      end
   end
endmodule

//--- design/fws_pkg.sv
// Package for the flash write status poller: register map, status bit positions,
// bus cycle timing and the carrier structs shared by the poller files.
// Assumes a byte-wide asynchronous parallel flash behind the pin driver.
package fws_pkg;
   // Clock and bus cycle timing
   localparam int CLK_NS          = 20;
   localparam int RD_STROBE_NS    = 120;
   localparam int RD_STROBE_CYC   = (RD_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_STROBE_NS    = 60;
   localparam int WR_STROBE_CYC   = (WR_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_NS          = 40;
   localparam int GAP_CYC         = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WINDOW_GAP_US   = 50;
   localparam int WINDOW_GAP_CYC  = (WINDOW_GAP_US * 1000) / CLK_NS;

   // Data-line status bit positions
   localparam int POLL_BIT        = 7;
   localparam int TOGGLE1_BIT     = 6;
   localparam int FAIL_BIT        = 5;
   localparam int WINDOW_BIT      = 3;
   localparam int TOGGLE2_BIT     = 2;

   // Commands on the data lines
   localparam logic [7:0] CMD_RESET = 8'hF0;

   // Register offsets (byte addresses)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_DATA   = 4'hC;

   // Control register fields
   localparam int CTRL_START      = 0;
   localparam int CTRL_MODE       = 1;
   localparam int CTRL_ABANDON    = 2;
   localparam int CTRL_RESET_CMD  = 3;
   localparam int CTRL_EXP_LSB    = 8;

   // Status register fields
   localparam int ST_BUSY         = 0;
   localparam int ST_DONE         = 1;
   localparam int ST_FAIL         = 2;
   localparam int ST_SUSPENDED    = 3;
   localparam int ST_IN_SECTOR    = 4;
   localparam int ST_WINDOW       = 5;
   localparam int ST_DATA_LSB     = 8;

   localparam logic [31:0] RESP_ZERO = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      FWS_POLL_TOGGLE,
      FWS_POLL_DATA,
      FWS_POLL_PEEK
   } fws_mode_e;

   // One request to the pin driver
   typedef struct packed {
      logic        write;
      logic [18:0] addr;
      logic [7:0]  wdata;
   } fws_req_s;

   // Result of one status poll
   typedef struct packed {
      logic       done;
      logic       fail;
      logic       suspended;
      logic       in_sector;
      logic       window;
      logic [7:0] data;
   } fws_result_s;
endpackage

//--- design/fws_poller.sv
// Flash write status poller: software starts a poll, the poller reads the
// flash status byte over the pin driver and reports done, fail and sector state.
// Assumes the flash is already running a program or erase started by software.
`timescale 1ns/1ps
module fws_poller
   import fws_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [18:0]      flash_addr,
   output logic             chip_enable_n,
   output logic             output_enable_n,
   output logic             write_enable_n,
   input  wire logic [7:0]  flash_dq_in,
   output logic [7:0]       flash_dq_out,
   output logic             flash_dq_oe
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_READ_A, ST_READ_B, ST_CHECK_FAIL, ST_READ_C, ST_RESET, ST_DATA, ST_FINISH
   } fws_state_e;

   fws_state_e  st_reg, st_next;
   fws_mode_e   mode_reg, mode_next;
   logic [18:0] addr_reg, addr_next;
   logic [7:0]  exp_reg, exp_next;
   logic [7:0]  first_reg, first_next;
   logic        auto_rst_reg, auto_rst_next;
   fws_result_s res_reg, res_next;
   logic        busy_reg, busy_next;
   logic        issued_reg, issued_next;
   logic        req_valid;
   logic        req_ready;
   fws_req_s    req;
   logic        pin_done;
   logic [7:0]  pin_data;
   logic        wr_pulse;
   logic [3:0]  wr_addr;
   logic [31:0] wr_data;
   logic [31:0] rd_ctrl;
   logic [31:0] rd_addr;
   logic [31:0] rd_status;
   logic [31:0] rd_dataw;
   logic        toggled;
   logic        ctrl_wr;

   fws_axil u_axil (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_pulse      (wr_pulse),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .rd_ctrl       (rd_ctrl),
      .rd_addr       (rd_addr),
      .rd_status     (rd_status),
      .rd_dataw      (rd_dataw)
   );

   fws_pins u_pins (
      .aclk            (aclk),
      .aresetn         (aresetn),
      .req_valid       (req_valid),
      .req_ready       (req_ready),
      .req             (req),
      .done_pulse      (pin_done),
      .rdata           (pin_data),
      .flash_addr      (flash_addr),
      .chip_enable_n   (chip_enable_n),
      .output_enable_n (output_enable_n),
      .write_enable_n  (write_enable_n),
      .flash_dq_in     (flash_dq_in),
      .flash_dq_out    (flash_dq_out),
      .flash_dq_oe     (flash_dq_oe)
   );

   // Register views for software
   assign ctrl_wr   = wr_pulse && (wr_addr == REG_CTRL);
   assign rd_ctrl   = {16'h0000, exp_reg, 4'h0, auto_rst_reg, 1'b0, mode_reg == FWS_POLL_DATA, 1'b0};
   assign rd_addr   = {13'h0000, addr_reg};
   assign rd_status = {16'h0000, res_reg.data, 2'h0, res_reg.window, res_reg.in_sector,
                       res_reg.suspended, res_reg.fail, res_reg.done, busy_reg};
   assign rd_dataw  = {24'h000000, first_reg};

   // Toggle bit one compared across two completed reads
   assign toggled = (first_reg[TOGGLE1_BIT] != pin_data[TOGGLE1_BIT]);

   // Request to the pin driver; the reset command is a single write of F0
   always_comb begin
      req.write = (st_reg == ST_RESET);
      req.addr  = addr_reg;
      req.wdata = CMD_RESET;
      req_valid = busy_reg && !issued_reg && (st_reg != ST_IDLE) && (st_reg != ST_FINISH);
   end

   // Polling sequence
   always_comb begin
      st_next       = st_reg;
      mode_next     = mode_reg;
      addr_next     = addr_reg;
      exp_next      = exp_reg;
      first_next    = first_reg;
      auto_rst_next = auto_rst_reg;
      res_next      = res_reg;
      busy_next     = busy_reg;
      issued_next   = issued_reg;
      if (req_valid && req_ready) begin
         issued_next = 1'b1;
      end
      if (pin_done) begin
         issued_next = 1'b0;
      end
      if (wr_pulse && (wr_addr == REG_ADDR) && !busy_reg) begin
         addr_next = wr_data[18:0];
      end
      if (ctrl_wr && wr_data[CTRL_ABANDON]) begin
         // Leaving the poll forces a fresh double read next time
         st_next   = ST_FINISH;
         busy_next = issued_next;
      end else begin
         case (st_reg)
            ST_IDLE: begin
               if (ctrl_wr && wr_data[CTRL_START]) begin
                  busy_next     = 1'b1;
                  mode_next     = wr_data[CTRL_MODE] ? FWS_POLL_DATA : FWS_POLL_TOGGLE;
                  exp_next      = wr_data[CTRL_EXP_LSB +: 8];
                  auto_rst_next = wr_data[CTRL_RESET_CMD];
                  res_next      = '0;
                  st_next       = ST_READ_A;
               end
            end
            ST_READ_A: begin
               if (pin_done) begin
                  first_next = pin_data;
                  st_next    = ST_READ_B;
               end
            end
            ST_READ_B: begin
               if (pin_done) begin
                  res_next.window    = pin_data[WINDOW_BIT];
                  res_next.in_sector = first_reg[TOGGLE2_BIT] != pin_data[TOGGLE2_BIT];
                  res_next.suspended = !toggled && res_next.in_sector && pin_data[POLL_BIT];
                  if (mode_reg == FWS_POLL_DATA) begin
                     // Poll bit matches expected bit seven once done
                     if (pin_data[POLL_BIT] == exp_reg[POLL_BIT]) begin
                        st_next = ST_DATA;
                     end else if (pin_data[FAIL_BIT]) begin
                        st_next = ST_CHECK_FAIL;
                     end else begin
                        first_next = pin_data;
                        st_next    = ST_READ_B;
                     end
                  end else if (!toggled) begin
                     st_next = ST_DATA;
                  end else if (pin_data[FAIL_BIT]) begin
                     first_next = pin_data;
                     st_next    = ST_CHECK_FAIL;
                  end else begin
                     first_next = pin_data;
                     st_next    = ST_READ_B;
                  end
               end
            end
            ST_CHECK_FAIL: begin
               st_next = ST_READ_C;
            end
            ST_READ_C: begin
               if (pin_done) begin
                  if ((mode_reg == FWS_POLL_DATA) ? (pin_data[POLL_BIT] == exp_reg[POLL_BIT]) : !toggled) begin
                     st_next = ST_DATA;
                  end else begin
                     res_next.fail = 1'b1;
                     st_next       = auto_rst_reg ? ST_RESET : ST_FINISH;
                     busy_next     = auto_rst_reg;
                     res_next.done = !auto_rst_reg;
                  end
               end
            end
            ST_RESET: begin
               if (pin_done) begin
                  res_next.done = 1'b1;
                  busy_next     = 1'b0;
                  st_next       = ST_FINISH;
               end
            end
            ST_DATA: begin
               // Valid array data only on the read after completion
               if (pin_done) begin
                  res_next.data = pin_data;
                  res_next.done = 1'b1;
                  busy_next     = 1'b0;
                  st_next       = ST_FINISH;
               end
            end
            ST_FINISH: begin
               // A cut poll waits out its bus cycle, so no stale byte counts as a first read
               if (!issued_next) begin
                  st_next   = ST_IDLE;
                  busy_next = 1'b0;
               end
            end
            default: st_next = ST_IDLE;
         endcase
      end
   end

   // Sequence registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg       <= ST_IDLE;
         mode_reg     <= FWS_POLL_TOGGLE;
         addr_reg     <= 19'h00000;
         exp_reg      <= 8'h00;
         first_reg    <= 8'h00;
         auto_rst_reg <= 1'b0;
         res_reg      <= '0;
         busy_reg     <= 1'b0;
         issued_reg   <= 1'b0;
      end else begin
         st_reg       <= st_next;
         mode_reg     <= mode_next;
         addr_reg     <= addr_next;
         exp_reg      <= exp_next;
         first_reg    <= first_next;
         auto_rst_reg <= auto_rst_next;
         res_reg      <= res_next;
         busy_reg     <= busy_next;
         issued_reg   <= issued_next;
      end
   end
endmodule
